//--- rtl/scl_pkg.sv
package scl_pkg;
  // register offsets and values after reset
  localparam logic [7:0] CFG_MODE_OFS  = 8'h2C;
  localparam logic [7:0] CFG_LINE_OFS  = 8'h2D;
  localparam logic [7:0] STATUS_OFS    = 8'h30;
  localparam logic [7:0] CFG_MODE_RST  = 8'h00;
  localparam logic [7:0] CFG_LINE_RST  = 8'h00;
  localparam logic [7:0] CFG_MODE_MASK = 8'hDF;
  // mode register fields
  localparam int MCE_POS = 6;
  localparam int PC_POS  = 2;
  localparam int SM_POS  = 0;
  // line register fields
  localparam int SHARED_POS = 7;
  localparam int GO_ACT_POS = 6;
  localparam int GO_LP_POS  = 5;
  localparam int DRIVER_POS = 4;
  localparam int FILL_POS   = 3;
  localparam int CLKM_POS   = 0;
  // port configuration codes
  localparam logic [2:0] PC_NRZ   = 3'h0;
  localparam logic [2:0] PC_BUS1  = 3'h1;
  localparam logic [2:0] PC_NRZI  = 3'h2;
  localparam logic [2:0] PC_BUS2  = 3'h3;
  localparam logic [2:0] PC_FM0   = 3'h4;
  localparam logic [2:0] PC_FM1   = 3'h5;
  localparam logic [2:0] PC_MANCH = 3'h6;
  // serial mode codes
  localparam logic [1:0] SM_HDLC   = 2'h0;
  localparam logic [1:0] SM_LOOP   = 2'h1;
  localparam logic [1:0] SM_BISYNC = 2'h2;
  localparam logic [1:0] SM_ASYNC  = 2'h3;
  // line patterns and run lengths
  localparam logic [7:0] FLAG_PATTERN    = 8'h7E;
  localparam logic [7:0] RELEASE_PATTERN = 8'h7F;
  localparam logic [2:0] STUFF_ONES      = 3'h5;
  localparam logic [2:0] INSERT_ZEROS    = 3'h7;
  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam int         TIMER_DIV_DEF   = 16;
  // synchroniser lanes
  localparam int SYN_RXCLK = 0;
  localparam int SYN_TXCLK = 1;
  localparam int SYN_RXD   = 2;
  localparam int SYN_TXD   = 3;
  localparam int SYN_XTAL  = 4;
  localparam int SYN_W     = 5;
  typedef enum logic [1:0] {
    TX_IDLE, TX_OPEN, TX_DATA, TX_CLOSE
  } scl_tx_state_type;
  typedef enum logic [1:0] {
    LOOP_OFF, LOOP_ON, LOOP_SEND
  } scl_loop_state_type;
endpackage

//--- rtl/scl_line_cfg.sv
`timescale 1ns/10ps
`default_nettype none
module scl_line_cfg
  import scl_pkg::*;
#(
  parameter int TIMER_DIV = TIMER_DIV_DEF
) (
  input  wire logic       ref_clk,           // core clock
  input  wire logic       rst,               // sync reset
  input  wire logic [7:0] reg_addr,          // register address
  input  wire logic [7:0] reg_wdata,         // write data
  input  wire logic       reg_wr,            // write strobe
  input  wire logic       reg_rd,            // read strobe
  output logic      [7:0] reg_rdata,         // read data
  input  wire logic       rx_clk,            // receive clock pin
  input  wire logic       tx_clk,            // transmit clock pin
  input  wire logic       crystal_input,     // crystal clock pin
  input  wire logic       pin_swap_control,  // swap data pins
  input  wire logic       rxd_in,            // receive pin in
  output logic            rxd_out,           // receive pin out
  output logic            rxd_oe,            // receive pin enable
  input  wire logic       txd_in,            // transmit pin in
  output logic            txd_out,           // transmit pin out
  output logic            txd_oe,            // transmit pin enable
  input  wire logic [7:0] tx_data,           // fifo head byte
  input  wire logic       tx_valid,          // fifo not empty
  input  wire logic       tx_last,           // head ends frame
  output logic            tx_ready,          // byte taken pulse
  output logic            rx_bit,            // received bit
  output logic            rx_bit_valid,      // received bit pulse
  output logic            master_clock_select, // crystal clocks core
  output logic      [2:0] clock_mode_field,  // clock mode 0..7
  output logic            timer_tick         // timer period pulse
);

  initial begin
    if (TIMER_DIV < 2 || TIMER_DIV > 255) begin
      $error("TIMER_DIV out of range");
    end
  end

  localparam logic [7:0] TDIV_LAST = 8'(TIMER_DIV - 1);

  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    sat_inc = (v == 3'h7) ? v : v + 3'h1;
  endfunction

  function automatic logic is_bus(input logic [2:0] pc);
    is_bus = (pc == PC_BUS1) || (pc == PC_BUS2);
  endfunction

  // bus configurations and the unused code fall back to NRZ
  function automatic logic [2:0] eff_code(input logic [2:0] pc);
    if (is_bus(pc) || pc == 3'h7) begin
      eff_code = PC_NRZ;
    end else begin
      eff_code = pc;
    end
  endfunction

  // pin synchronisers; stage s1 feeds s2 only
  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] s1;
  logic [SYN_W-1:0] s2;
  logic [SYN_W-1:0] s3;
  logic [SYN_W-1:0] rise;
  logic [SYN_W-1:0] fall;

  assign pin_raw = {crystal_input, txd_in, rxd_in, tx_clk, rx_clk};
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // configuration registers
  logic [7:0] mode_q;
  logic [7:0] line_q;
  logic [7:0] next_mode;
  logic [7:0] next_line;
  logic [7:0] next_rdata;
  logic [7:0] status_word;

  logic [2:0] pc;
  logic [1:0] sm;
  logic       bus_cfg;
  logic       loop_mode;
  logic       fill_bit;
  logic       go_act;
  logic       go_loop;
  logic       drv_pp;
  logic       stuff_en;
  logic       oin_en;
  logic       idle_flags;
  logic [2:0] code;

  assign pc        = mode_q[PC_POS +: 3];
  assign sm        = mode_q[SM_POS +: 2];
  assign bus_cfg   = is_bus(pc);
  assign code      = eff_code(pc);
  assign loop_mode = (sm == SM_LOOP);
  assign fill_bit  = line_q[FILL_POS];
  assign go_act    = line_q[GO_ACT_POS];
  assign go_loop   = line_q[GO_LP_POS];
  assign drv_pp    = line_q[DRIVER_POS];
  assign stuff_en  = (sm == SM_HDLC) || loop_mode;
  assign oin_en    = bus_cfg & fill_bit;

  always_comb begin
    next_mode  = mode_q;
    next_line  = line_q;
    next_rdata = 8'h00;
    if (reg_wr) begin
      if (reg_addr == CFG_MODE_OFS) begin
        next_mode = reg_wdata & CFG_MODE_MASK;
      end else if (reg_addr == CFG_LINE_OFS) begin
        next_line = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == CFG_MODE_OFS) begin
        next_rdata = mode_q;
      end else if (reg_addr == CFG_LINE_OFS) begin
        next_rdata = line_q;
      end else if (reg_addr == STATUS_OFS) begin
        next_rdata = status_word;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q    <= CFG_MODE_RST;
      line_q    <= CFG_LINE_RST;
      reg_rdata <= 8'h00;
    end else begin
      mode_q    <= next_mode;
      line_q    <= next_line;
      reg_rdata <= next_rdata;
    end
  end

  assign master_clock_select = mode_q[MCE_POS];
  assign clock_mode_field    = line_q[CLKM_POS +: 3];

  // loop state and receive history
  scl_loop_state_type loop_q;
  scl_loop_state_type next_loop;
  logic [7:0] hist;
  logic [7:0] next_hist;
  logic       dly;
  logic       next_dly;
  logic       rx_src;
  logic       swap_act;
  logic       eop;
  logic       send_enter;

  scl_tx_state_type tx_st;
  logic [2:0] bitcnt;

  assign swap_act = pin_swap_control & ~bus_cfg;
  assign rx_src   = swap_act ? s2[SYN_TXD] : s2[SYN_RXD];
  assign eop      = ({hist[6:0], rx_src} == RELEASE_PATTERN);
  assign send_enter = (loop_q == LOOP_ON) && (next_loop == LOOP_SEND);
  // in sending state the gaps carry flags whatever the fill bit says
  assign idle_flags = (loop_q == LOOP_SEND) |
                      (~bus_cfg & fill_bit);

  always_comb begin
    next_loop = loop_q;
    next_hist = hist;
    next_dly  = dly;
    if (!loop_mode) begin
      next_loop = LOOP_OFF;
    end else if (rise[SYN_RXCLK]) begin
      next_hist = {hist[6:0], rx_src};
      next_dly  = rx_src;
      case (loop_q)
        LOOP_OFF: begin
          if (eop && go_loop) begin
            next_loop = LOOP_ON;
          end
        end
        LOOP_ON: begin
          if (eop && !go_loop) begin
            next_loop = LOOP_OFF;
          end else if (eop && go_act) begin
            next_loop = LOOP_SEND;
          end
        end
        default: begin
        end
      endcase
    end
    if (loop_mode && loop_q == LOOP_SEND && !go_act &&
        tx_st == TX_IDLE && bitcnt == 3'h0 && !tx_valid) begin
      next_loop = LOOP_ON;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loop_q <= LOOP_OFF;
      hist   <= 8'h00;
      dly    <= 1'b1;
    end else begin
      loop_q <= next_loop;
      hist   <= next_hist;
      dly    <= next_dly;
    end
  end

  // transmitter
  scl_tx_state_type next_tx_st;
  logic [2:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [2:0] ones;
  logic [2:0] next_ones;
  logic [2:0] zeros;
  logic [2:0] next_zeros;
  logic       last_q;
  logic       next_last;
  logic       done_q;
  logic       next_done;
  logic       cur_bit;
  logic       next_cur_bit;
  logic       next_ready;
  logic       tx_go;

  assign tx_go = tx_valid & (~loop_mode | (loop_q == LOOP_SEND));

  always_comb begin
    logic bit_o;
    logic ld;
    bit_o        = 1'b1;
    ld           = 1'b0;
    next_tx_st   = tx_st;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_ones    = ones;
    next_zeros   = zeros;
    next_last    = last_q;
    next_done    = done_q;
    next_cur_bit = cur_bit;
    next_ready   = 1'b0;
    if (rise[SYN_TXCLK]) begin
      case (tx_st)
        TX_IDLE: begin
          if (idle_flags) begin
            bit_o       = FLAG_PATTERN[bitcnt];
            next_bitcnt = bitcnt + 3'h1;
            // an idle flag doubles as the opening flag
            if (bitcnt == LAST_BIT && tx_go) begin
              ld = 1'b1;
            end
          end else begin
            next_bitcnt = 3'h0;
            if (tx_go) begin
              next_tx_st = TX_OPEN;
            end
          end
        end
        TX_OPEN: begin
          bit_o       = FLAG_PATTERN[bitcnt];
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == LAST_BIT) begin
            if (tx_valid) begin
              ld = 1'b1;
            end else begin
              next_tx_st = TX_IDLE;
            end
          end
        end
        TX_DATA: begin
          if (stuff_en && ones == STUFF_ONES) begin
            bit_o = 1'b0;
          end else if (oin_en && zeros == INSERT_ZEROS) begin
            bit_o = 1'b1;
          end else begin
            bit_o       = shreg[0];
            next_shreg  = {1'b1, shreg[7:1]};
            next_bitcnt = bitcnt + 3'h1;
            next_done   = (bitcnt == LAST_BIT);
          end
          next_ones  = bit_o ? sat_inc(ones) : 3'h0;
          next_zeros = bit_o ? 3'h0 : sat_inc(zeros);
          // a run ended by the last data bit still owes its extra bit
          if (next_done && !(stuff_en && next_ones == STUFF_ONES) &&
              !(oin_en && next_zeros == INSERT_ZEROS)) begin
            next_done = 1'b0;
            // underrun closes the frame rather than stalling
            if (last_q || !tx_valid) begin
              next_tx_st = TX_CLOSE;
            end else begin
              ld = 1'b1;
            end
          end
        end
        default: begin
          bit_o       = FLAG_PATTERN[bitcnt];
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == LAST_BIT) begin
            if (tx_go && line_q[SHARED_POS]) begin
              ld = 1'b1;
            end else if (tx_go) begin
              next_tx_st = TX_OPEN;
            end else begin
              next_tx_st = TX_IDLE;
            end
          end
        end
      endcase
      next_cur_bit = bit_o;
    end
    if (ld) begin
      next_tx_st  = TX_DATA;
      next_shreg  = tx_data;
      next_last   = tx_last;
      next_bitcnt = 3'h0;
      next_ones   = 3'h0;
      next_zeros  = 3'h0;
      next_done   = 1'b0;
      next_ready  = 1'b1;
    end
    // the flag that starts sending ends the release pattern
    if (send_enter) begin
      next_tx_st  = TX_IDLE;
      next_done   = 1'b0;
      next_bitcnt = 3'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_st    <= TX_IDLE;
      bitcnt   <= 3'h0;
      shreg    <= 8'hFF;
      ones     <= 3'h0;
      zeros    <= 3'h0;
      last_q   <= 1'b0;
      done_q   <= 1'b0;
      cur_bit  <= 1'b1;
      tx_ready <= 1'b0;
    end else begin
      tx_st    <= next_tx_st;
      bitcnt   <= next_bitcnt;
      shreg    <= next_shreg;
      ones     <= next_ones;
      zeros    <= next_zeros;
      last_q   <= next_last;
      done_q   <= next_done;
      cur_bit  <= next_cur_bit;
      tx_ready <= next_ready;
    end
  end

  // line coder: bit start on rising, mid-cell on falling edge
  logic lvl;
  logic next_lvl;

  always_comb begin
    next_lvl = lvl;
    if (rise[SYN_TXCLK]) begin
      case (code)
        PC_NRZI:  next_lvl = next_cur_bit ? lvl : ~lvl;
        PC_FM0:   next_lvl = ~lvl;
        PC_FM1:   next_lvl = ~lvl;
        PC_MANCH: next_lvl = next_cur_bit;
        default:  next_lvl = next_cur_bit;
      endcase
    end else if (fall[SYN_TXCLK]) begin
      case (code)
        PC_FM0:   next_lvl = cur_bit ? lvl : ~lvl;
        PC_FM1:   next_lvl = cur_bit ? ~lvl : lvl;
        PC_MANCH: next_lvl = ~cur_bit;
        default:  next_lvl = lvl;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lvl <= 1'b1;
    end else begin
      lvl <= next_lvl;
    end
  end

  // pin drivers
  logic line_out;
  logic pin_o;
  logic pin_e;

  always_comb begin
    line_out = lvl;
    if (loop_mode) begin
      case (loop_q)
        LOOP_OFF:  line_out = rx_src;
        LOOP_ON:   line_out = dly;
        default:   line_out = lvl;
      endcase
    end
    // open drain only ever pulls low
    pin_o = drv_pp ? line_out : 1'b0;
    pin_e = drv_pp ? 1'b1 : ~line_out;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd_out <= 1'b0;
      txd_oe  <= 1'b0;
      rxd_out <= 1'b0;
      rxd_oe  <= 1'b0;
    end else begin
      txd_out <= swap_act ? 1'b0 : pin_o;
      txd_oe  <= swap_act ? 1'b0 : pin_e;
      rxd_out <= swap_act ? pin_o : 1'b0;
      rxd_oe  <= swap_act ? pin_e : 1'b0;
    end
  end

  // receiver one deletion
  logic [2:0] rz;
  logic [2:0] next_rz;
  logic       next_rx_bit;
  logic       next_rx_valid;

  always_comb begin
    next_rz       = rz;
    next_rx_bit   = rx_bit;
    next_rx_valid = 1'b0;
    if (rise[SYN_RXCLK]) begin
      if (oin_en && rz == INSERT_ZEROS) begin
        next_rz = 3'h0;
      end else begin
        next_rx_bit   = rx_src;
        next_rx_valid = 1'b1;
        next_rz       = rx_src ? 3'h0 : sat_inc(rz);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rz           <= 3'h0;
      rx_bit       <= 1'b1;
      rx_bit_valid <= 1'b0;
    end else begin
      rz           <= next_rz;
      rx_bit       <= next_rx_bit;
      rx_bit_valid <= next_rx_valid;
    end
  end

  // timer; crystal edges when the master clock is chosen
  logic [7:0] tcnt;
  logic [7:0] next_tcnt;
  logic       next_tick;
  logic       tsrc;

  assign tsrc = mode_q[MCE_POS] ? rise[SYN_XTAL]
                                : rise[SYN_TXCLK];

  always_comb begin
    next_tcnt = tcnt;
    next_tick = 1'b0;
    if (tsrc) begin
      if (tcnt == TDIV_LAST) begin
        next_tcnt = 8'h00;
        next_tick = 1'b1;
      end else begin
        next_tcnt = tcnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tcnt       <= 8'h00;
      timer_tick <= 1'b0;
    end else begin
      tcnt       <= next_tcnt;
      timer_tick <= next_tick;
    end
  end

  assign status_word = {2'h0, code, (tx_st != TX_IDLE),
                        (loop_q == LOOP_SEND), (loop_q != LOOP_OFF)};

endmodule
`default_nettype wire

//--- verification/scl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module scl_chk
  import scl_pkg::*;
(
  input wire logic       ref_clk,             // core clock
  input wire logic       rst,                 // sync reset
  input wire logic [7:0] reg_addr,            // register address
  input wire logic [7:0] reg_wdata,           // write data
  input wire logic       reg_wr,              // write strobe
  input wire logic       reg_rd,              // read strobe
  input wire logic [7:0] reg_rdata,           // read data
  input wire logic       rx_clk,              // receive clock pin
  input wire logic       tx_clk,              // transmit clock pin
  input wire logic       crystal_input,       // crystal clock pin
  input wire logic       rxd_out,             // receive pin out
  input wire logic       rxd_oe,              // receive pin enable
  input wire logic       txd_out,             // transmit pin out
  input wire logic       txd_oe,              // transmit pin enable
  input wire logic       tx_ready,            // byte taken pulse
  input wire logic       rx_bit_valid,        // received bit pulse
  input wire logic       master_clock_select, // crystal clocks core
  input wire logic [2:0] clock_mode_field,    // clock mode
  input wire logic       timer_tick           // timer pulse
);
  logic [2:0] prev, next_prev;
  logic [2:0] tx_age, rx_age, xt_age;
  logic [2:0] next_tx_age, next_rx_age, next_xt_age;

  // cycles since a raw pin rose, saturating so old edges never excuse a pulse
  function automatic logic [2:0] aged(input logic [2:0] a, input logic r);
    aged = r ? 3'h0 : (a == 3'h7 ? a : a + 3'h1);
  endfunction

  always_comb begin
    next_prev = {crystal_input, rx_clk, tx_clk};
    next_tx_age = rst ? 3'h7 : aged(tx_age, tx_clk & ~prev[0]);
    next_rx_age = rst ? 3'h7 : aged(rx_age, rx_clk & ~prev[1]);
    next_xt_age = rst ? 3'h7 : aged(xt_age, crystal_input & ~prev[2]);
  end

  always_ff @(posedge ref_clk) begin
    prev <= next_prev;
    tx_age <= next_tx_age;
    rx_age <= next_rx_age;
    xt_age <= next_xt_age;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence wr_mode_s;
    reg_wr && reg_addr == CFG_MODE_OFS;
  endsequence
  sequence wr_line_s;
    reg_wr && reg_addr == CFG_LINE_OFS;
  endsequence
  sequence rd_back_s(logic [7:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  mclk_sel_a:
  assert property (wr_mode_s |=> master_clock_select == $past(reg_wdata[6]))
  else $error("master clock select not loaded");
  mclk_hold_a:
  assert property (!(reg_wr && reg_addr == CFG_MODE_OFS)
    |=> $stable(master_clock_select))
  else $error("master clock select changed without write");
  mode_back_a:
  assert property (wr_mode_s ##1 rd_back_s(CFG_MODE_OFS)
    |=> reg_rdata == ($past(reg_wdata, 2) & CFG_MODE_MASK))
  else $error("mode register read back wrong");
  clk_mode_a:
  assert property (wr_line_s |=> clock_mode_field == $past(reg_wdata[2:0]))
  else $error("clock mode field not loaded");
  line_back_a:
  assert property (wr_line_s ##1 rd_back_s(CFG_LINE_OFS)
    |=> reg_rdata == $past(reg_wdata, 2))
  else $error("line register read back wrong");
  timer_src_a:
  assert property (timer_tick && master_clock_select |-> xt_age <= 3'h6)
  else $error("timer tick without crystal edge");
  tick_gap_a:
  assert property (timer_tick |=> !timer_tick [*3])
  else $error("timer ticks too close");
  txd_drive_a:
  assert property (txd_out |-> txd_oe)
  else $error("transmit pin high while undriven");
  rxd_drive_a:
  assert property (rxd_out |-> rxd_oe)
  else $error("receive pin high while undriven");
  ready_bit_a:
  assert property (tx_ready |-> tx_age <= 3'h6)
  else $error("byte taken without bit clock");
  ready_gap_a:
  assert property (tx_ready |=> !tx_ready [*8])
  else $error("bytes taken too close");
  rx_valid_a:
  assert property (rx_bit_valid |-> rx_age <= 3'h6)
  else $error("received bit without bit clock");
endmodule
`default_nettype wire

//--- verification/scl_remote.sv
`timescale 1ns/10ps
`default_nettype none
module scl_remote;
  logic         link_clk;  // bit clock of the remote station
  logic         rxd_drive; // data toward the receive pin
  logic         txd_line;  // resolved transmit line, set by the bench
  logic [255:0] hist;      // transmit line history, newest bit at 0

  initial begin
    link_clk = 1'b0;
    rxd_drive = 1'b1;
    hist = '0;
  end

  // the clock only runs inside a burst; an idle line keeps marking ones
  task automatic run(input int n, input logic [15:0] b, input int nb);
    hist = '0;
    for (int i = 0; i < n; i++) begin
      rxd_drive = (i < nb) ? b[nb - 1 - i] : 1'b1;
      #200;
      link_clk = 1'b1;
      hist = {hist[254:0], txd_line};
      #200;
      link_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import scl_pkg::*;
  logic       ref_clk, rst, reg_wr, reg_rd, crystal, swap;
  logic       tx_valid, tx_last, tx_ready, rx_bit, rx_bit_valid;
  logic       rxd_out, rxd_oe, txd_out, txd_oe, mcs, timer_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, d;
  logic [2:0] cmf;
  logic [7:0] fb [4];
  int         nb, idx, nrx, ntick, mismatches, tests_run;
  wire logic  txd_line, rxd_line;

  // open drain transmit line has a pull-up
  assign txd_line = txd_oe ? txd_out : 1'b1;
  assign rxd_line = rxd_oe ? rxd_out : remote_i.rxd_drive;
  always_comb remote_i.txd_line = txd_line;

  scl_remote remote_i ();
  scl_line_cfg #(.TIMER_DIV(4)) scl_line_cfg_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_clk(remote_i.link_clk),
    .tx_clk(remote_i.link_clk), .crystal_input(crystal),
    .pin_swap_control(swap), .rxd_in(rxd_line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_in(txd_line), .txd_out(txd_out),
    .txd_oe(txd_oe), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .master_clock_select(mcs),
    .clock_mode_field(cmf), .timer_tick(timer_tick));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // single-byte frames popped on each taken pulse
  always @(posedge ref_clk) begin
    if (rx_bit_valid === 1'b1) nrx++;
    if (timer_tick === 1'b1) ntick++;
    if (tx_ready === 1'b1) idx++;
    tx_valid <= idx < nb;
    tx_last <= idx < nb;
    tx_data <= fb[idx % 4];
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic burst(input logic [7:0] m, input logic [7:0] l,
                       input logic [15:0] b, input int n);
    wr(CFG_MODE_OFS, m);
    wr(CFG_LINE_OFS, l);
    nrx = 0;
    remote_i.run(80, b, n);
    repeat (8) @(posedge ref_clk);
  endtask

  function automatic logic found(input logic [63:0] p, input int len);
    logic [63:0] m;
    m = (64'h1 << len) - 64'h1;
    found = 1'b0;
    for (int s = 0; s <= 256 - len; s++) begin
      if ((64'(remote_i.hist >> s) & m) == (p & m)) found = 1'b1;
    end
  endfunction

  initial begin
    #4000000;
    mismatches++;
    test_done;
  end

  initial begin
    logic [7:0] v;
    rst = 1'b1;
    {reg_wr, reg_rd, crystal, swap, tx_valid, tx_last} = '0;
    {reg_addr, reg_wdata, tx_data} = '0;
    {nb, idx, nrx, ntick, mismatches, tests_run} = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(CFG_MODE_OFS, d);
    chk8(d, CFG_MODE_RST);
    rd(CFG_LINE_OFS, d);
    chk8(d, CFG_LINE_RST);
    for (int c = 0; c < 8; c++) begin
      wr(CFG_LINE_OFS, 8'(c));
      rd(CFG_LINE_OFS, d);
      chk8(d, 8'(c));
      chk8({5'h0, cmf}, 8'(c));
    end
    wr(8'h40, 8'hFF);
    rd(8'h40, d);
    chk8(d, 8'h00);
    rd(CFG_LINE_OFS, d);
    chk8(d, 8'h07);
    for (int c = 0; c < 8; c++) begin
      v = 8'(c << 2) | 8'(c % 4);
      wr(CFG_MODE_OFS, v);
      rd(CFG_MODE_OFS, d);
      chk8(d, v);
      rd(STATUS_OFS, d);
      v = (c == 1 || c == 3 || c == 7) ? 8'h00 : 8'(c << 3);
      chk8(d & 8'h38, v);
    end
    wr(CFG_MODE_OFS, 8'hFF);
    rd(CFG_MODE_OFS, d);
    chk8(d, 8'hDF);
    chk8({7'h0, mcs}, 8'h01);
    ntick = 0;
    repeat (16) begin
      crystal <= 1'b1;
      repeat (3) @(posedge ref_clk);
      crystal <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
    chk8(8'(ntick), 8'h04);
    // master clock off before insertion and loop work
    burst(8'h00, 8'h10, 16'h0, 0);
    chk8(8'(found(64'hFFFFFFFF, 32)), 8'h01);
    chk8({6'h0, txd_oe, txd_out}, 8'h03);
    burst(8'h00, 8'h18, 16'h0, 0);
    chk8(8'(found(64'h7E7E, 16)), 8'h01);
    burst(8'h00, 8'h08, 16'h0, 0);
    chk8(8'(found(64'h7E7E, 16)), 8'h01);
    chk8({7'h0, txd_out}, 8'h00);
    burst(8'h04, 8'h18, 16'h0, 0);
    chk8(8'(found(64'hFFFFFFFF, 32)), 8'h01);
    @(negedge ref_clk);
    fb[0] = 8'h01;
    idx = 0;
    nb = 1;
    @(posedge ref_clk);
    burst(8'h04, 8'h18, 16'hC07F, 16);
    chk8(8'(found({8'h7E, 9'h101, 8'h7E}, 25)), 8'h01);
    chk8(8'(nrx), 8'd79);
    @(negedge ref_clk);
    fb[0] = 8'hFF;
    fb[1] = 8'hFF;
    idx = 0;
    nb = 2;
    @(posedge ref_clk);
    burst(8'h00, 8'h90, 16'h0, 0);
    v = 8'(found({8'h7E, 9'h1F7, 8'h7E, 9'h1F7, 8'h7E}, 42));
    chk8(v, 8'h01);
    chk8(8'(nrx), 8'd80);
    burst(8'h00, 8'h30, 16'h007F, 16);
    rd(STATUS_OFS, d);
    chk8(d & 8'h03, 8'h00);
    burst(8'h01, 8'h30, 16'h007F, 16);
    rd(STATUS_OFS, d);
    chk8(d & 8'h03, 8'h01);
    burst(8'h01, 8'h70, 16'h007F, 16);
    rd(STATUS_OFS, d);
    chk8(d & 8'h03, 8'h03);
    chk8(8'(found(64'h7E7E, 16)), 8'h01);
    burst(8'h01, 8'h30, 16'h0, 0);
    burst(8'h01, 8'h30, 16'hA5C3, 16);
    rd(STATUS_OFS, d);
    chk8(d & 8'h03, 8'h01);
    chk8(8'(found(64'hA5C3, 16)), 8'h01);
    burst(8'h01, 8'h10, 16'h007F, 16);
    rd(STATUS_OFS, d);
    chk8(d & 8'h03, 8'h00);
    test_done;
  end
endmodule

bind scl_line_cfg scl_chk scl_chk_i (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_clk(rx_clk), .tx_clk(tx_clk),
  .crystal_input(crystal_input), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
  .txd_out(txd_out), .txd_oe(txd_oe), .tx_ready(tx_ready),
  .rx_bit_valid(rx_bit_valid), .master_clock_select(master_clock_select),
  .clock_mode_field(clock_mode_field), .timer_tick(timer_tick));
`default_nettype wire
